// ---- design/tcce_top.sv ----
// Purpose: slot 16 signalling evaluator deriving echo slot enables
// Assumes: classic Wishbone slave, octets and strobe on the same clock
// Notes: one octet per frame yields flags for two slots
//
// Notes on behaviour
// - evaluation acts only while enable field set
// - path field picks send or receive octet
// - active flag bit marks enabled slot, polarity selectable
// - polarity toggle acts like incoming bit change
// - bit select picks pair d, c, b, a

`timescale 1ns/1ps
`default_nettype none

module tcce_top
	import tcce_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [WB_DATA_W-1:0] wb_dat_i,
	input wire logic [WB_SEL_W-1:0] wb_sel_i,
	output logic [WB_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// frame stream
	input wire logic slot16_strobe,
	input wire logic [7:0] send_octet,
	input wire logic [7:0] recv_octet,
	// slot enables
	output logic slot_enable_hi,
	output logic slot_enable_lo
);

	// the decoder reads address bits 7:2, so a narrower bus cannot be served
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
		$error("ADDR_W must lie between 8 and 32");
	end

	////////////////////////////////////////////////////////////////////////////////
	// register bus

	tcce_config_s cfg_reg, cfg_next;
	logic ack_reg, ack_next;
	logic [WB_DATA_W-1:0] dat_reg, dat_next;
	logic [7:0] octet_held;
	logic octet_seen;
	tcce_flags_s flags;
	logic req;
	logic [7:0] word_addr;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		return addr == offset;
	endfunction

	assign req = wb_cyc_i && wb_stb_i;
	// upper address bits beyond the map are ignored; map aliases above 256 bytes
	assign word_addr = {wb_adr_i[7:2], 2'b00};

	// ack one cycle after the request; write commits at the edge ack is seen
	always_comb begin
		ack_next = req && !ack_reg;
		dat_next = dat_reg;
		cfg_next = cfg_reg;
		if (req && !ack_reg) begin
			dat_next = '0;
			if (hit(word_addr, CONFIG_OFFSET)) begin
				dat_next[CFG_WIDTH-1:0] = cfg_reg;
			end else if (hit(word_addr, STATUS_OFFSET)) begin
				dat_next[STAT_OCTET_POS +: 8] = octet_held;
				dat_next[STAT_FLAGS_POS +: 2] = flags;
				dat_next[STAT_SEEN_POS] = octet_seen;
			end
		end
		if (req && ack_reg && wb_we_i && wb_sel_i[0] && hit(word_addr, CONFIG_OFFSET)) begin
			cfg_next = tcce_config_s'(wb_dat_i[CFG_WIDTH-1:0]);
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cfg_reg <= tcce_config_s'(CFG_RESET);
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	////////////////////////////////////////////////////////////////////////////////
	// datapath

	tcce_octet_latch u_latch (
		.clock(clock),
		.nrst(nrst),
		.slot16_strobe(slot16_strobe),
		.send_octet(send_octet),
		.recv_octet(recv_octet),
		.path_select(cfg_reg.path_select),
		.octet_held(octet_held),
		.octet_seen(octet_seen)
	);

	tcce_flag_eval u_eval (
		.clock(clock),
		.nrst(nrst),
		.octet_held(octet_held),
		.cfg(cfg_reg),
		.flags(flags)
	);

	assign slot_enable_hi = flags.hi;
	assign slot_enable_lo = flags.lo;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_ack_follows;
		@(posedge clock) disable iff (!nrst)
		req && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");

	property p_ack_single;
		@(posedge clock) disable iff (!nrst)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held too long");

	property p_frame_to_flags;
		@(posedge clock) disable iff (!nrst)
		slot16_strobe && cfg_reg.eval_enable && $stable(cfg_reg) && !cfg_reg.polarity_invert
		&& cfg_reg.bit_select == TCCE_PAIR_C && cfg_reg.path_select
		##1 $stable(cfg_reg)
		|=> {slot_enable_hi, slot_enable_lo} == {$past(send_octet[5], 2), $past(send_octet[1], 2)};
	endproperty
	a_frame_to_flags: assert property (p_frame_to_flags) else $error("frame to flags wrong");

	property p_cfg_write;
		@(posedge clock) disable iff (!nrst)
		req && wb_ack_o && wb_we_i && wb_sel_i[0] && word_addr == CONFIG_OFFSET
		|=> cfg_reg == $past(wb_dat_i[CFG_WIDTH-1:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

	// refused writes: status, unmapped words and lane 0 masked off
	property p_cfg_hold;
		@(posedge clock) disable iff (!nrst)
		!(req && wb_ack_o && wb_we_i && wb_sel_i[0] && word_addr == CONFIG_OFFSET)
		|=> $stable(cfg_reg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

	property p_ack_idle;
		@(posedge clock) disable iff (!nrst)
		!req |=> !wb_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

	// read data is taken with ack, then held until the next request
	property p_read_config;
		@(posedge clock) disable iff (!nrst)
		req && !wb_ack_o && word_addr == CONFIG_OFFSET
		|=> wb_dat_o[CFG_WIDTH-1:0] == $past(cfg_reg)
		&& wb_dat_o[WB_DATA_W-1:CFG_WIDTH] == '0;
	endproperty
	a_read_config: assert property (p_read_config) else $error("config read wrong");

	property p_read_status;
		@(posedge clock) disable iff (!nrst)
		req && !wb_ack_o && word_addr == STATUS_OFFSET
		|=> wb_dat_o[STAT_OCTET_POS +: 8] == $past(octet_held)
		&& wb_dat_o[STAT_FLAGS_POS +: 2] == $past(flags)
		&& wb_dat_o[STAT_SEEN_POS] == $past(octet_seen)
		&& wb_dat_o[WB_DATA_W-1:STAT_SEEN_POS+1] == '0;
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read wrong");

	property p_read_unmapped;
		@(posedge clock) disable iff (!nrst)
		req && !wb_ack_o && word_addr != CONFIG_OFFSET && word_addr != STATUS_OFFSET
		|=> wb_dat_o == '0;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

	property p_dat_hold;
		@(posedge clock) disable iff (!nrst)
		!(req && !wb_ack_o) |=> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");

	// receive path with inverted pair b, the mirror of the send path check
	property p_frame_recv;
		@(posedge clock) disable iff (!nrst)
		slot16_strobe && cfg_reg.eval_enable && $stable(cfg_reg) && cfg_reg.polarity_invert
		&& cfg_reg.bit_select == TCCE_PAIR_B && !cfg_reg.path_select
		##1 $stable(cfg_reg)
		|=> {slot_enable_hi, slot_enable_lo} == ~{$past(recv_octet[6], 2), $past(recv_octet[2], 2)};
	endproperty
	a_frame_recv: assert property (p_frame_recv) else $error("receive frame flags wrong");

	// no octet and no config change for two cycles: enables must stand
	property p_flags_hold;
		@(posedge clock) disable iff (!nrst)
		!slot16_strobe ##1 !slot16_strobe && $stable(cfg_reg)
		|=> $stable({slot_enable_hi, slot_enable_lo});
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("enables moved between octets");

	property p_seen_sticky;
		@(posedge clock) disable iff (!nrst)
		slot16_strobe || octet_seen |=> octet_seen;
	endproperty
	a_seen_sticky: assert property (p_seen_sticky) else $error("capture mark lost");

	c_send_frame: cover property (@(posedge clock) disable iff (!nrst)
		slot16_strobe && cfg_reg.path_select && cfg_reg.eval_enable);
	c_recv_frame: cover property (@(posedge clock) disable iff (!nrst)
		slot16_strobe && !cfg_reg.path_select && cfg_reg.eval_enable);
	c_disable: cover property (@(posedge clock) disable iff (!nrst)
		$fell(cfg_reg.eval_enable));

endmodule // tcce_top

`default_nettype wire

// ---- design/tcce_pkg.sv ----
// Purpose: shared constants, types and helpers for the slot 16 signalling evaluator
// Assumes: one 100 MHz clock, 32-bit classic Wishbone register access
// Notes: register map is word aligned; narrow registers sit in the low bits

`default_nettype none

package tcce_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus and register map
	localparam int WB_DATA_W = 32;
	localparam int WB_SEL_W = 4;
	localparam logic [7:0] CONFIG_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;

	// configuration field positions
	localparam int CFG_WIDTH = 6;
	localparam int CFG_EVAL_ENABLE_POS = 5;
	localparam int CFG_PATH_SELECT_POS = 4;
	localparam int CFG_INVERT_POS = 3;
	localparam int CFG_BIT_SELECT_POS = 1;
	localparam int CFG_STATE_HOLD_POS = 0;
	localparam logic [5:0] CFG_RESET = 6'h12;

	// status field positions
	localparam int STAT_OCTET_POS = 0;
	localparam int STAT_FLAGS_POS = 8;
	localparam int STAT_SEEN_POS = 10;

	// held state after reset
	localparam logic [7:0] OCTET_RESET = 8'h00;
	localparam logic [1:0] FLAGS_RESET = 2'h3;

	// bit pair choice: signalling bit a, b, c or d
	typedef enum logic [1:0] {
		TCCE_PAIR_D = 2'h0,
		TCCE_PAIR_C = 2'h1,
		TCCE_PAIR_B = 2'h2,
		TCCE_PAIR_A = 2'h3
	} tcce_pair_e;

	typedef struct packed {
		logic eval_enable;
		logic path_select;
		logic polarity_invert;
		tcce_pair_e bit_select;
		logic state_hold;
	} tcce_config_s;

	typedef struct packed {
		logic hi;
		logic lo;
	} tcce_flags_s;

	// upper nibble bit serves the first slot, lower nibble bit the second
	function automatic tcce_flags_s tcce_pick_pair(input logic [7:0] octet, input tcce_pair_e sel);
		tcce_flags_s f;
		f.hi = octet[4 + 32'(sel)];
		f.lo = octet[32'(sel)];
		return f;
	endfunction

	// active flag marks an enabled slot; evaluation off leaves every slot enabled
	function automatic tcce_flags_s tcce_eval(input logic [7:0] octet, input tcce_config_s cfg);
		tcce_flags_s f;
		f = tcce_pick_pair(octet, cfg.bit_select);
		if (!cfg.eval_enable) begin
			f = FLAGS_RESET;
		end else if (cfg.polarity_invert) begin
			f = ~f;
		end
		return f;
	endfunction

endpackage

`default_nettype wire

// ---- design/tcce_octet_latch.sv ----
// Purpose: takes the slot 16 octet from the chosen path and holds it
// Assumes: octets and strobe come from logic on the same clock
// Notes: nothing changes between strobes

`timescale 1ns/1ps
`default_nettype none

module tcce_octet_latch
	import tcce_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// stream side
	input wire logic slot16_strobe,
	input wire logic [7:0] send_octet,
	input wire logic [7:0] recv_octet,
	input wire logic path_select,
	// held result
	output logic [7:0] octet_held,
	output logic octet_seen
);

	logic [7:0] octet_reg, octet_next;
	logic seen_reg, seen_next;

	always_comb begin
		octet_next = octet_reg;
		seen_next = seen_reg;
		if (slot16_strobe) begin
			octet_next = path_select ? send_octet : recv_octet;
			seen_next = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			octet_reg <= OCTET_RESET;
			seen_reg <= 1'b0;
		end else begin
			octet_reg <= octet_next;
			seen_reg <= seen_next;
		end
	end

	assign octet_held = octet_reg;
	assign octet_seen = seen_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_hold_between;
		@(posedge clock) disable iff (!nrst)
		!slot16_strobe |=> $stable(octet_held);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("octet changed without strobe");

	property p_send_path;
		@(posedge clock) disable iff (!nrst)
		slot16_strobe && path_select |=> octet_held == $past(send_octet);
	endproperty
	a_send_path: assert property (p_send_path) else $error("send octet not taken");

	property p_recv_path;
		@(posedge clock) disable iff (!nrst)
		slot16_strobe && !path_select |=> octet_held == $past(recv_octet);
	endproperty
	a_recv_path: assert property (p_recv_path) else $error("receive octet not taken");

endmodule // tcce_octet_latch

`default_nettype wire

// ---- design/tcce_flag_eval.sv ----
// Purpose: turns the held octet into two slot enable flags
// Assumes: configuration is stable register state on the same clock
// Notes: flags follow both octet and configuration one cycle later

`timescale 1ns/1ps
`default_nettype none

module tcce_flag_eval
	import tcce_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// inputs
	input wire logic [7:0] octet_held,
	input wire tcce_config_s cfg,
	// flags
	output tcce_flags_s flags
);

	tcce_flags_s flags_reg, flags_next;

	// re-evaluated every cycle, so a polarity toggle acts like a flipped bit
	always_comb begin
		flags_next = tcce_eval(octet_held, cfg);
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_disabled_all_on;
		@(posedge clock) disable iff (!nrst)
		!cfg.eval_enable |=> flags == FLAGS_RESET;
	endproperty
	a_disabled_all_on: assert property (p_disabled_all_on) else $error("flags moved while off");

	property p_pair_a_plain;
		@(posedge clock) disable iff (!nrst)
		cfg.eval_enable && !cfg.polarity_invert && cfg.bit_select == TCCE_PAIR_A
		|=> flags == {$past(octet_held[7]), $past(octet_held[3])};
	endproperty
	a_pair_a_plain: assert property (p_pair_a_plain) else $error("pair a plain wrong");

	property p_pair_d_inverted;
		@(posedge clock) disable iff (!nrst)
		cfg.eval_enable && cfg.polarity_invert && cfg.bit_select == TCCE_PAIR_D
		|=> flags == ~{$past(octet_held[4]), $past(octet_held[0])};
	endproperty
	a_pair_d_inverted: assert property (p_pair_d_inverted) else $error("pair d inverted wrong");

	property p_toggle_invert;
		@(posedge clock) disable iff (!nrst)
		cfg.eval_enable && $stable(cfg.eval_enable) && $changed(cfg.polarity_invert)
		&& $stable(cfg.bit_select) && $stable(octet_held)
		|=> flags == ~$past(flags);
	endproperty
	a_toggle_invert: assert property (p_toggle_invert) else $error("invert toggle missed");

	c_invert_toggle: cover property (@(posedge clock) disable iff (!nrst)
		cfg.eval_enable && $changed(cfg.polarity_invert));

endmodule // tcce_flag_eval

`default_nettype wire

// ---- tb/tcce_pcm_model.sv ----
// Purpose: stand-in for the pcm stream that carries slot 16 signalling
// Assumes: bench asks for one octet pair at a time
// Notes: octet lines flip every cycle outside slot 16

`timescale 1ns/1ps
`default_nettype none

module tcce_pcm_model (
	// clock
	input wire logic clock,
	// bench request
	input wire logic go,
	input wire logic [7:0] send_val,
	input wire logic [7:0] recv_val,
	// stream
	output logic slot16_strobe,
	output logic [7:0] send_octet,
	output logic [7:0] recv_octet
);
	// other slots pass between strobes, so the lines never keep a stale copy
	always_ff @(posedge clock) begin
		slot16_strobe <= go;
		send_octet <= go ? send_val : ~send_octet;
		recv_octet <= go ? recv_val : ~recv_octet;
	end
endmodule // tcce_pcm_model

`default_nettype wire

// ---- tb/ts16_cas_channel_enable_test.sv ----
// Purpose: self-checking bench for the slot 16 evaluator
// Assumes: one clock, classic Wishbone, ack one cycle after request
// Notes: expected flags worked out from octet, pair and polarity

`timescale 1ns/1ps
`default_nettype none

module ts16_cas_channel_enable_test
	import tcce_pkg::*;
;
	logic clock = 0, nrst = 0, cyc = 0, stb = 0, we = 0, go = 0;
	logic [7:0] adr = 0, sv = 0, rv = 0, o;
	logic [31:0] dat = 0, q;
	logic [3:0] sel = 0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, strobe, hi, lo;
	logic [7:0] so, ro;
	int n_fail = 0, comparisons = 0;

	tcce_pcm_model u_pcm (.clock(clock), .go(go), .send_val(sv), .recv_val(rv),
		.slot16_strobe(strobe), .send_octet(so), .recv_octet(ro));
	tcce_top u_dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slot16_strobe(strobe),
		.send_octet(so), .recv_octet(ro), .slot_enable_hi(hi), .slot_enable_lo(lo));

	initial begin
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// one classic cycle; waits for ack with a bound
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		i = 0;
		@(posedge clock);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do begin
			@(posedge clock);
			#1;
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			print_verdict();
		end else begin
			q = wb_dat_o;
			@(posedge clock);
			cyc <= 0;
			stb <= 0;
		end
	endtask

	// config write, then one edge for flags to follow
	task automatic cfg(input logic e, input logic p, input logic i, input logic [1:0] s);
		wb(1, CONFIG_OFFSET, {26'h0, e, p, i, s, 1'b0}, 4'h1);
		@(posedge clock);
		#1;
	endtask

	task automatic pcm(input logic [7:0] s, input logic [7:0] r);
		@(posedge clock);
		go <= 1;
		sv <= s;
		rv <= r;
		@(posedge clock);
		go <= 0;
		repeat (2) @(posedge clock);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("flags", {hi, lo}, 2'h3);
		wb(0, CONFIG_OFFSET, 0, 4'hf);
		chk("config", q, 32'h12);
		wb(0, STATUS_OFFSET, 0, 4'hf);
		chk("status", q, 32'h300);
		wb(0, 8'h08, 0, 4'hf);
		chk("unmapped", q, 0);
	endtask

	// every pair, polarity and path; send and receive octets differ everywhere
	task automatic t_table();
		for (int s = 0; s < 4; s++) begin
			for (int i = 0; i < 2; i++) begin
				for (int p = 0; p < 2; p++) begin
					cfg(1, p[0], i[0], s[1:0]);
					pcm(8'h96, 8'h69);
					o = p ? 8'h96 : 8'h69;
					chk("pair", {hi, lo}, {o[4+s] ^ i[0], o[s] ^ i[0]});
				end
			end
		end
	endtask

	task automatic t_hold();
		cfg(1, 1, 0, 2'h3);
		pcm(8'h96, 8'h69);
		repeat (5) @(posedge clock);
		#1;
		chk("held", {hi, lo}, 2'h2);
		cfg(1, 1, 1, 2'h3);
		chk("invert", {hi, lo}, 2'h1);
		cfg(0, 1, 1, 2'h3);
		chk("off", {hi, lo}, 2'h3);
		pcm(8'h00, 8'hff);
		chk("off2", {hi, lo}, 2'h3);
		wb(0, STATUS_OFFSET, 0, 4'hf);
		chk("status2", q, 32'h700);
		cfg(1, 1, 0, 2'h3);
		chk("reenable", {hi, lo}, 2'h0);
	endtask

	// writes that must not land
	task automatic t_refuse();
		wb(1, CONFIG_OFFSET, 0, 4'he);
		wb(1, 8'h08, 0, 4'hf);
		wb(1, STATUS_OFFSET, 0, 4'hf);
		wb(0, CONFIG_OFFSET, 0, 4'hf);
		chk("config2", q, 32'h36);
		chk("flags2", {hi, lo}, 2'h0);
	endtask

	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1;
		@(posedge clock);
		#1;
		t_reset();
		t_table();
		t_hold();
		t_refuse();
		print_verdict();
	end
endmodule // ts16_cas_channel_enable_test

`default_nettype wire
